// ### rtl/dbr_pkg.sv
// Purpose: shared constants and types for the burst and refresh command core
// Assumes: 100 MHz core clock, commands sampled on the rising edge
// Notes:   timing figures are plain defaults, not characterised values
package dbr_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RFC_NS      = 160;
  localparam int T_CKE_NS      = 5;
  localparam int T_SR_REFI_NS  = 7800;
  // least times round up, the internal refresh interval rounds down
  localparam int T_RFC_CYC_I   = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CKE_RAW     = (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CKE_CYC_I   = (T_CKE_RAW < 1) ? 1 : T_CKE_RAW;
  localparam int T_SR_REFI_I   = T_SR_REFI_NS / CLK_PERIOD_NS;

  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] T_RFC_LOAD  = TMR_W'(T_RFC_CYC_I - 1);
  localparam logic [TMR_W-1:0] T_REFI_LOAD = TMR_W'(T_SR_REFI_I - 1);

  // ****************************************
  // widths and fields
  // ****************************************
  localparam int ADDR_W     = 14;
  localparam int COL_W      = 10;
  localparam int ROW_W      = 14;
  localparam int BANK_W     = 3;
  localparam int NUM_BANKS  = 8;
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int BURST_BIT  = 12;
  localparam int AUTOPRE_BIT = 10;

  localparam logic [3:0] BEATS_CHOP = 4'h4;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [ROW_W-1:0] ROW_RESET = 14'h0000;
  localparam logic [NUM_BANKS-1:0] BANKS_CLOSED = 8'h00;

  // {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REF  = 2'b01,
    ST_SR   = 2'b11,
    ST_SRX  = 2'b10
  } dbr_state_t;

endpackage : dbr_pkg

// ### rtl/dbr_timer.sv
// Purpose: loadable down counter used for refresh cycle and retention timing
// Assumes: load wins over counting
// Notes:   done is high while the count sits at zero
`timescale 1ns/1ps
module dbr_timer #(
  parameter int W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic              done_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = load_val_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == '0);
endmodule : dbr_timer

// ### rtl/dbr_fifo.sv
// Purpose: small write-data FIFO with valid/ready on both sides
// Assumes: single clock, synchronous reset
// Notes:   pointers carry one extra bit so full and empty are exact
`timescale 1ns/1ps
module dbr_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW:0]  wp_r;
  logic [PW:0]  rp_r;
  logic         push;
  logic         pop;

  assign out_valid_o = (wp_r != rp_r);
  assign in_ready_o  = !((wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]));
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_r[rp_r[PW-1:0]];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (ce_i) begin
      if (push) begin
        wp_r <= wp_r + (PW+1)'(1);
      end
      if (pop) begin
        rp_r <= rp_r + (PW+1)'(1);
      end
    end
  end

  // storage needs no reset: a slot is only read after it was written
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_r[wp_r[PW-1:0]] <= in_data_i;
    end
  end
endmodule : dbr_fifo

// ### rtl/dbr_core.sv
// Purpose: command decode for burst length, refresh and self retention
// Assumes: command pins synchronous to clk_i; controller keeps its own timing
// Notes:   write data beats pass through an 8-deep FIFO toward the array
`timescale 1ns/1ps
module dbr_core
  import dbr_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [BANK_W-1:0] ba_i,
  input  wire logic              mr1_dll_off_i,
  input  wire logic              wr_beat_valid_i,
  input  wire logic [DATA_W-1:0] wr_beat_data_i,
  input  wire logic              wr_timing_err_i,
  output logic                   wr_beat_ready_o,
  output logic                   mem_data_valid_o,
  input  wire logic              mem_data_ready_i,
  output logic [DATA_W-1:0]      mem_data_o,
  output logic                   mem_data_corrupt_o,
  output logic                   col_valid_o,
  output logic                   col_write_o,
  output logic [COL_W-1:0]       col_addr_o,
  output logic [BANK_W-1:0]      col_bank_o,
  output logic [3:0]             burst_beats_o,
  output logic                   auto_pre_o,
  output logic                   ref_active_o,
  output logic [ROW_W-1:0]       ref_row_o,
  output logic                   sr_refresh_o,
  output logic                   self_retention_o,
  output logic                   banks_idle_o,
  output logic                   dll_on_o,
  output logic                   dll_reset_o,
  output logic                   internal_clk_en_o
);

  // ****************************************
  // command decode
  // ****************************************
  logic [2:0] cmd3;
  logic       sel;
  logic       cke_q_r;
  logic       ref_cmd;
  logic       sre_cmd;
  logic       rw_cmd;
  logic       act_cmd;
  logic       pre_cmd;

  assign cmd3    = {ras_n_i, cas_n_i, we_n_i};
  assign sel     = !cs_n_i && cke_q_r;
  assign ref_cmd = sel && cke_i && (cmd3 == CMD_REF);
  assign sre_cmd = sel && !cke_i && (cmd3 == CMD_REF);
  assign rw_cmd  = sel && cke_i && ((cmd3 == CMD_RD) || (cmd3 == CMD_WR));
  assign act_cmd = sel && cke_i && (cmd3 == CMD_ACT);
  assign pre_cmd = sel && cke_i && (cmd3 == CMD_PRE);

  // ****************************************
  // state and counters
  // ****************************************
  dbr_state_t           state_r, state_nxt;
  logic [ROW_W-1:0]     row_r, row_nxt;
  logic [NUM_BANKS-1:0] open_r, open_nxt;
  logic                 col_valid_r, col_valid_nxt;
  logic                 col_write_r, col_write_nxt;
  logic [COL_W-1:0]     col_addr_r, col_addr_nxt;
  logic [BANK_W-1:0]    col_bank_r, col_bank_nxt;
  logic [3:0]           beats_r, beats_nxt;
  logic                 apre_r, apre_nxt;
  logic                 srref_r, srref_nxt;
  logic                 dll_on_r, dll_on_nxt;
  logic                 dll_rst_r, dll_rst_nxt;
  logic                 rfc_load;
  logic                 rfc_done;
  logic                 refi_load;
  logic                 refi_done;
  logic                 idle;

  assign idle = (state_r == ST_IDLE);

  always_comb begin
    state_nxt     = state_r;
    row_nxt       = row_r;
    open_nxt      = open_r;
    col_valid_nxt = 1'b0;
    col_write_nxt = col_write_r;
    col_addr_nxt  = col_addr_r;
    col_bank_nxt  = col_bank_r;
    beats_nxt     = beats_r;
    apre_nxt      = apre_r;
    srref_nxt     = 1'b0;
    dll_on_nxt    = dll_on_r;
    dll_rst_nxt   = 1'b0;
    rfc_load      = 1'b0;
    refi_load     = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        dll_on_nxt = !mr1_dll_off_i;
        if (ref_cmd) begin
          state_nxt = ST_REF;
          rfc_load  = 1'b1;
        end else if (sre_cmd) begin
          // refresh at once so the first one lands within tCKE, one cycle after entry
          state_nxt  = ST_SR;
          srref_nxt  = 1'b1;
          refi_load  = 1'b1;
          dll_on_nxt = 1'b0;
        end else if (rw_cmd) begin
          col_valid_nxt = 1'b1;
          col_write_nxt = (cmd3 == CMD_WR);
          col_addr_nxt  = addr_i[COL_W-1:0];
          col_bank_nxt  = ba_i;
          beats_nxt     = addr_i[BURST_BIT] ? BEATS_FULL : BEATS_CHOP;
          apre_nxt      = addr_i[AUTOPRE_BIT];
          if (addr_i[AUTOPRE_BIT]) begin
            open_nxt[ba_i] = 1'b0;
          end
        end else if (act_cmd) begin
          open_nxt[ba_i] = 1'b1;
        end else if (pre_cmd) begin
          if (addr_i[AUTOPRE_BIT]) begin
            open_nxt = BANKS_CLOSED;
          end else begin
            open_nxt[ba_i] = 1'b0;
          end
        end
      end
      ST_REF: begin
        // the pins are not looked at here; the row comes from row_r
        if (rfc_done) begin
          state_nxt = ST_IDLE;
          row_nxt   = row_r + ROW_W'(1);
          open_nxt  = BANKS_CLOSED;
        end
      end
      ST_SR: begin
        // only cke is watched; every other pin is ignored
        if (cke_i) begin
          state_nxt = ST_SRX;
        end else if (refi_done) begin
          srref_nxt = 1'b1;
          refi_load = 1'b1;
        end
        if (srref_r) begin
          row_nxt = row_r + ROW_W'(1);
        end
      end
      ST_SRX: begin
        state_nxt   = ST_IDLE;
        dll_on_nxt  = !mr1_dll_off_i;
        dll_rst_nxt = !mr1_dll_off_i;
        open_nxt    = BANKS_CLOSED;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r     <= ST_IDLE;
      cke_q_r     <= 1'b0;
      row_r       <= ROW_RESET;
      open_r      <= BANKS_CLOSED;
      col_valid_r <= 1'b0;
      col_write_r <= 1'b0;
      col_addr_r  <= '0;
      col_bank_r  <= '0;
      beats_r     <= BEATS_FULL;
      apre_r      <= 1'b0;
      srref_r     <= 1'b0;
      dll_on_r    <= 1'b0;
      dll_rst_r   <= 1'b0;
    end else if (ce_i) begin
      state_r     <= state_nxt;
      cke_q_r     <= cke_i;
      row_r       <= row_nxt;
      open_r      <= open_nxt;
      col_valid_r <= col_valid_nxt;
      col_write_r <= col_write_nxt;
      col_addr_r  <= col_addr_nxt;
      col_bank_r  <= col_bank_nxt;
      beats_r     <= beats_nxt;
      apre_r      <= apre_nxt;
      srref_r     <= srref_nxt;
      dll_on_r    <= dll_on_nxt;
      dll_rst_r   <= dll_rst_nxt;
    end
  end

  dbr_timer #(.W(TMR_W)) u_rfc_tmr (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .load_i     (rfc_load),
    .load_val_i (T_RFC_LOAD),
    .done_o     (rfc_done)
  );

  // internal retention timer keeps refreshing with no commands, counting clk_i cycles
  dbr_timer #(.W(TMR_W)) u_refi_tmr (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .load_i     (refi_load),
    .load_val_i (T_REFI_LOAD),
    .done_o     (refi_done)
  );

  // ****************************************
  // write data path
  // ****************************************
  // a strobe fault only tags its own beat; nothing else in the core reacts
  logic [DATA_W:0] fifo_out;

  dbr_fifo #(.W(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_valid_i  (wr_beat_valid_i),
    .in_ready_o  (wr_beat_ready_o),
    .in_data_i   ({wr_timing_err_i, wr_beat_data_i}),
    .out_valid_o (mem_data_valid_o),
    .out_ready_i (mem_data_ready_i),
    .out_data_o  (fifo_out)
  );

  assign mem_data_o         = fifo_out[DATA_W-1:0];
  assign mem_data_corrupt_o = fifo_out[DATA_W];

  // ****************************************
  // outputs
  // ****************************************
  assign col_valid_o       = col_valid_r;
  assign col_write_o       = col_write_r;
  assign col_addr_o        = col_addr_r;
  assign col_bank_o        = col_bank_r;
  assign burst_beats_o     = beats_r;
  assign auto_pre_o        = apre_r;
  assign ref_active_o      = (state_r == ST_REF);
  assign ref_row_o         = row_r;
  assign sr_refresh_o      = srref_r;
  assign self_retention_o  = (state_r == ST_SR);
  assign banks_idle_o      = (open_r == BANKS_CLOSED);
  assign dll_on_o          = dll_on_r;
  assign dll_reset_o       = dll_rst_r;
  assign internal_clk_en_o = (state_r != ST_SR);

  // ****************************************
  // assertions
  // ****************************************
  localparam int SR_FIRST_MAX = T_CKE_CYC_I;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i || !ce_i);

  a_burst_len_sel: assert property (idle && rw_cmd |=>
    burst_beats_o == ($past(addr_i[BURST_BIT]) ? BEATS_FULL : BEATS_CHOP))
    else $error("burst length does not follow A12");
  a_col_no_a12: assert property (idle && rw_cmd |=> col_valid_o &&
    col_addr_o == $past(addr_i[COL_W-1:0]))
    else $error("column address wrong");
  a_err_no_hang: assert property (idle && wr_timing_err_i && !ref_cmd && !sre_cmd
    |=> idle) else $error("strobe fault disturbed the core");
  a_ref_decode: assert property (idle && ref_cmd |=> ref_active_o)
    else $error("refresh not started");
  a_ref_row_held: assert property (ref_active_o && $past(ref_active_o)
    |-> $stable(ref_row_o)) else $error("refresh row moved mid cycle");
  a_ref_banks_idle: assert property (ref_active_o ##1 idle |-> banks_idle_o)
    else $error("banks open after refresh");
  a_sre_decode: assert property (idle && sre_cmd |=> self_retention_o)
    else $error("retention entry missed");
  a_dll_off_sr: assert property (self_retention_o |-> !dll_on_o)
    else $error("loop still on in retention");
  a_dll_reset_exit: assert property (self_retention_o && cke_i && !mr1_dll_off_i
    ##1 !mr1_dll_off_i |=> dll_reset_o && dll_on_o)
    else $error("loop not reset on exit");
  a_sr_ignores: assert property (self_retention_o && !cke_i |=>
    self_retention_o && !col_valid_o && !internal_clk_en_o)
    else $error("input acted on in retention");
  a_sr_first_ref: assert property (idle && sre_cmd |-> ##[1:SR_FIRST_MAX] sr_refresh_o)
    else $error("no refresh after retention entry");

  c_chop_read: cover property (idle && rw_cmd && !addr_i[BURST_BIT]);
  c_refresh: cover property (ref_active_o ##1 idle);
  c_retention: cover property (self_retention_o ##1 state_r == ST_SRX);
  c_fifo_full: cover property (wr_beat_valid_i && !wr_beat_ready_o);

endmodule : dbr_core

// ### test/dbr_ctrl_model.sv
// Purpose: controller model driving command pins and write beats
// Assumes: pins move 1 ns after the rising edge and hold across that edge
// Notes: the clock never stops, so clock stop and restart margins hold
`timescale 1ns/1ps
module dbr_ctrl_model
  import dbr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rdy_i,
  output logic              cke_o,
  output logic              cs_n_o,
  output logic [2:0]        cmd_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [BANK_W-1:0] ba_o,
  output logic              vld_o,
  output logic [DATA_W-1:0] data_o,
  output logic              err_o
);
  // ****************************************
  // command side
  // ****************************************
  // termination is never enabled by this model, so it is off at entry
  initial begin
    {cke_o, cs_n_o, cmd_o, vld_o, err_o} = 7'h7c;
    addr_o = '0;
    ba_o   = '0;
    data_o = '0;
  end

  // pins stay until the next call, so the caller decides the spacing
  task automatic cmd(input logic [2:0] code, input logic [ADDR_W-1:0] a,
                     input logic [BANK_W-1:0] b, input logic ke);
    cke_o  = ke;
    cs_n_o = 1'b0;
    cmd_o  = code;
    addr_o = a;
    ba_o   = b;
    @(posedge clk_i);
    #1;
  endtask : cmd

  // deselect with clock enable left alone, so retention stays held
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      cs_n_o = 1'b1;
      cmd_o  = 3'h7;
      addr_o = ~addr_o;
      ba_o   = ~ba_o;
      @(posedge clk_i);
      #1;
    end
  endtask : idle

  // exit is clock enable high together with a deselect
  task automatic wake();
    cke_o  = 1'b1;
    cs_n_o = 1'b1;
    @(posedge clk_i);
    #1;
  endtask : wake

  // ****************************************
  // write beats
  // ****************************************
  task automatic push(input int n, input logic [DATA_W-1:0] base, input int bad);
    for (int i = 0; i < n; i++) begin
      vld_o  = 1'b1;
      data_o = base + DATA_W'(i);
      err_o  = (i == bad);
      do @(posedge clk_i); while (rdy_i !== 1'b1);
      #1;
    end
    vld_o  = 1'b0;
    data_o = ~data_o;
    err_o  = 1'b0;
  endtask : push
endmodule : dbr_ctrl_model

// ### test/test_ddr3_burst_refresh_selfrefresh.sv
// Purpose: self-checking bench for the burst, refresh and retention core
// Assumes: the controller model drives pins 1 ns after each rising edge
// Notes:   the FIFO drain side is stalled on purpose until it is full
`timescale 1ns/1ps
`define DBR_CHK(act, exp) \
  begin \
    comparisons++; \
    if ((act) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] t=%0t act=%0h exp=%0h", $time, (act), (exp)); \
    end \
  end
module test_ddr3_burst_refresh_selfrefresh;
  import dbr_pkg::*;

  localparam int T_XS_CYC    = 20;
  localparam int TIMEOUT_CYC = 5000;

  logic              clk_i = 1'b0;
  logic              reset_i, ce_i, mr1_dll_off_i, mem_data_ready_i;
  logic              cke, cs_n, bvld, berr, wr_beat_ready_o;
  logic [2:0]        cmd;
  logic [ADDR_W-1:0] addr;
  logic [BANK_W-1:0] ba, col_bank_o;
  logic [DATA_W-1:0] bdata, mem_data_o;
  logic              mem_data_valid_o, mem_data_corrupt_o, col_valid_o, col_write_o;
  logic [COL_W-1:0]  col_addr_o;
  logic [3:0]        burst_beats_o;
  logic              auto_pre_o, ref_active_o, sr_refresh_o, self_retention_o;
  logic              banks_idle_o, dll_on_o, dll_reset_o, internal_clk_en_o;
  logic [ROW_W-1:0]  ref_row_o, exp_row;
  int                error_cnt = 0, comparisons = 0, cyc = 0;

  always #5 clk_i = ~clk_i;

  dbr_ctrl_model i_ctrl (
    .clk_i(clk_i), .rdy_i(wr_beat_ready_o), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd),
    .addr_o(addr), .ba_o(ba), .vld_o(bvld), .data_o(bdata), .err_o(berr)
  );

  dbr_core i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .cke_i(cke),
    .cs_n_i(cs_n), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
    .addr_i(addr), .ba_i(ba), .mr1_dll_off_i(mr1_dll_off_i), .wr_beat_valid_i(bvld),
    .wr_beat_data_i(bdata), .wr_timing_err_i(berr), .wr_beat_ready_o(wr_beat_ready_o),
    .mem_data_valid_o(mem_data_valid_o), .mem_data_ready_i(mem_data_ready_i),
    .mem_data_o(mem_data_o), .mem_data_corrupt_o(mem_data_corrupt_o),
    .col_valid_o(col_valid_o), .col_write_o(col_write_o), .col_addr_o(col_addr_o),
    .col_bank_o(col_bank_o), .burst_beats_o(burst_beats_o), .auto_pre_o(auto_pre_o),
    .ref_active_o(ref_active_o), .ref_row_o(ref_row_o), .sr_refresh_o(sr_refresh_o),
    .self_retention_o(self_retention_o), .banks_idle_o(banks_idle_o),
    .dll_on_o(dll_on_o), .dll_reset_o(dll_reset_o), .internal_clk_en_o(internal_clk_en_o)
  );

  // ****************************************
  // scenarios
  // ****************************************
  // all four read/write and chop/full mixes, with A11 and A13 set as bait
  task automatic t_burst();
    logic [ADDR_W-1:0] a;
    for (int i = 0; i < 4; i++) begin
      a = {1'b1, i[1], 1'b1, i[0], 10'h2a0 + 10'(i)};
      i_ctrl.cmd(i[0] ? CMD_WR : CMD_RD, a, 3'(i), 1'b1);
      `DBR_CHK(col_valid_o, 1'b1)
      `DBR_CHK(burst_beats_o, i[1] ? BEATS_FULL : BEATS_CHOP)
      `DBR_CHK(col_addr_o, a[9:0])
      `DBR_CHK({col_write_o, auto_pre_o, col_bank_o}, {i[0], i[0], 3'(i)})
      i_ctrl.idle(3);
    end
    `DBR_CHK(col_valid_o, 1'b0)
  endtask : t_burst

  task automatic t_fifo();
    mem_data_ready_i = 1'b0;
    for (int k = 0; k < 2; k++) begin
      i_ctrl.cmd(CMD_WR, 14'h0040, 3'h1, 1'b1);
      i_ctrl.idle(1);
      i_ctrl.push(4, 16'h1000 + 16'(k * 4), (k == 0) ? 2 : 9);
    end
    `DBR_CHK({wr_beat_ready_o, mem_data_valid_o}, 2'b01)
    i_ctrl.cmd(CMD_RD, 14'h1040, 3'h1, 1'b1);
    `DBR_CHK(col_valid_o, 1'b1)
    i_ctrl.idle(1);
    for (int i = 0; i < 8; i++) begin
      `DBR_CHK({mem_data_valid_o, mem_data_corrupt_o, mem_data_o}, {1'b1, i == 2, 16'h1000 + 16'(i)})
      mem_data_ready_i = 1'b1;
      @(posedge clk_i);
      #1;
    end
    mem_data_ready_i = 1'b0;
    `DBR_CHK({wr_beat_ready_o, mem_data_valid_o}, 2'b10)
  endtask : t_fifo

  // the address bus carries junk during refresh; the row must come from the counter
  task automatic t_ref();
    int n;
    i_ctrl.cmd(CMD_REF, 14'h3c3c, 3'h5, 1'b1);
    `DBR_CHK(ref_active_o, 1'b1)
    n = 1;
    while (ref_active_o === 1'b1 && n < 100) begin
      i_ctrl.idle(1);
      n++;
    end
    exp_row++;
    `DBR_CHK(n - 1, T_RFC_CYC_I)
    `DBR_CHK({ref_row_o, banks_idle_o}, {exp_row, 1'b1})
  endtask : t_ref

  // a low enable in mid refresh must stretch the cycle, not shorten or restart it
  task automatic t_freeze();
    int n;
    i_ctrl.cmd(CMD_REF, 14'h1234, 3'h6, 1'b1);
    ce_i = 1'b0;
    i_ctrl.idle(4);
    `DBR_CHK({ref_active_o, ref_row_o}, {1'b1, exp_row})
    ce_i = 1'b1;
    n = 1;
    while (ref_active_o === 1'b1 && n < 100) begin
      i_ctrl.idle(1);
      n++;
    end
    exp_row++;
    `DBR_CHK(n - 1, T_RFC_CYC_I)
    `DBR_CHK({ref_row_o, banks_idle_o}, {exp_row, 1'b1})
  endtask : t_freeze

  task automatic t_bank();
    i_ctrl.cmd(CMD_ACT, 14'h0100, 3'h3, 1'b1);
    i_ctrl.idle(2);
    `DBR_CHK(banks_idle_o, 1'b0)
    i_ctrl.cmd(CMD_PRE, 14'h0400, 3'h0, 1'b1);
    i_ctrl.idle(2);
    `DBR_CHK(banks_idle_o, 1'b1)
    for (int i = 0; i < 2; i++) t_ref();
  endtask : t_bank

  // nothing is postponed here, and every bank is already closed
  task automatic t_sr(input logic off);
    int n;
    mr1_dll_off_i = off;
    i_ctrl.cmd(CMD_REF, 14'h0c0c, 3'h2, 1'b0);
    `DBR_CHK({self_retention_o, sr_refresh_o}, 2'b11)
    `DBR_CHK({internal_clk_en_o, dll_on_o}, 2'b00)
    i_ctrl.cmd(CMD_RD, 14'h0123, 3'h0, 1'b0);
    exp_row++;
    `DBR_CHK({col_valid_o, ref_row_o}, {1'b0, exp_row})
    n = 1;
    while (sr_refresh_o !== 1'b1 && n < 2000) begin
      i_ctrl.idle(1);
      n++;
    end
    `DBR_CHK(n, T_SR_REFI_I)
    i_ctrl.idle(1);
    exp_row++;
    `DBR_CHK(ref_row_o, exp_row)
    i_ctrl.wake();
    `DBR_CHK({self_retention_o, internal_clk_en_o}, 2'b01)
    i_ctrl.idle(1);
    `DBR_CHK({dll_reset_o, dll_on_o}, {~off, ~off})
    i_ctrl.idle(T_XS_CYC);
    t_ref();
  endtask : t_sr

  // ****************************************
  // verdict and watchdog
  // ****************************************
  task automatic final_report();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == TIMEOUT_CYC) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    reset_i          = 1'b1;
    ce_i             = 1'b1;
    mr1_dll_off_i    = 1'b0;
    mem_data_ready_i = 1'b0;
    exp_row          = '0;
    repeat (8) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    i_ctrl.idle(3);
    `DBR_CHK({ref_row_o, burst_beats_o, banks_idle_o}, {14'h0, BEATS_FULL, 1'b1})
    t_burst();
    t_fifo();
    t_bank();
    t_freeze();
    t_sr(1'b0);
    t_sr(1'b1);
    final_report();
  end
endmodule : test_ddr3_burst_refresh_selfrefresh
